// File: design/uirq_pkg.sv
// Package for the serial-port interrupt routing block.
// Assumes a 32-bit AXI4-Lite register bus.
package uirq_pkg;
  localparam logic [7:0] MODE_OFS   = 8'hf0;
  localparam logic [7:0] STAT_OFS   = 8'hf4;
  localparam logic [7:0] MASK_OFS   = 8'hf8;
  localparam logic [7:0] PINS_OFS   = 8'hfc;
  localparam logic [7:0] MODE_RST   = 8'h00;
  localparam logic [3:0] IRQ_RST    = 4'h0;
  localparam int         MIDI_BIT   = 0;
  localparam int         HS_BIT     = 1;
  localparam int         SHARE_BIT  = 7;
  localparam logic [7:0] MODE_WMASK = 8'h83;
  localparam logic [1:0] RESP_OKAY  = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef struct packed {
    logic gate;
    logic req;
  } uirq_port_t;

  typedef struct packed {
    logic o;
    logic oe;
  } uirq_pin_t;
endpackage

// File: design/uirq_route.sv
// Mode register and interrupt pin routing for two serial ports.
// Assumes AXI4-Lite master, port requests synchronous to aclk.
// Behaviour
// - Mode bit 0 enables MIDI support; reset value 0.
// - Mode bit 1 enables high-speed operation; reset value 0.
// - Share bit 0: each pin follows only its own port.
// - Share bit 1: both pins show the combined gated request.
// - Unshared pin floats when gate is 0, else shows the request.
// - Sharing with two routed lines asserts both on either request.
//
// Register access over AXI4-Lite was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module uirq_route
  import uirq_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire uirq_port_t  serial_port_one,
  input  wire uirq_port_t  serial_port_two,
  output uirq_pin_t        irq_pin_one,
  output uirq_pin_t        irq_pin_two,
  output logic             midi_en,
  output logic             high_speed_en,
  output logic             irq
);
  logic [7:0] mode_ff;
  logic [3:0] stat_ff;
  logic [3:0] mask_ff;
  logic       aw_ff, w_ff;
  logic [7:0] awaddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;
  uirq_pin_t  pin1_ff, pin2_ff;
  logic       irq_ff, midi_ff, hs_ff;
  logic [1:0] prev_req_ff;

  // Pin routing
  wire share     = mode_ff[SHARE_BIT];
  wire req1      = serial_port_one.gate & serial_port_one.req;
  wire req2      = serial_port_two.gate & serial_port_two.req;
  wire any_gate  = serial_port_one.gate | serial_port_two.gate;
  wire any_req   = req1 | req2;
  // Shared mode drives both lines with the OR; tolerated by design
  wire nxt_o1    = share ? any_req  : req1;
  wire nxt_oe1   = share ? any_gate : serial_port_one.gate;
  wire nxt_o2    = share ? any_req  : req2;
  wire nxt_oe2   = share ? any_gate : serial_port_two.gate;

  // Events: rise of each gated request, request with gate closed per port
  wire [1:0] cur_req = {req2, req1};
  wire [3:0] events  = {~serial_port_two.gate & serial_port_two.req,
                        ~serial_port_one.gate & serial_port_one.req,
                        cur_req & ~prev_req_ff};

  // Register bus decode
  wire wr_go   = aw_ff & w_ff & ~s_axi_bvalid;
  wire wr_mode = wr_go & (awaddr_ff == MODE_OFS) & wstrb_ff[0];
  wire wr_stat = wr_go & (awaddr_ff == STAT_OFS) & wstrb_ff[0];
  wire wr_mask = wr_go & (awaddr_ff == MASK_OFS) & wstrb_ff[0];
  wire wr_ok   = (awaddr_ff == MODE_OFS) | (awaddr_ff == STAT_OFS) |
                 (awaddr_ff == MASK_OFS) | (awaddr_ff == PINS_OFS);
  wire rd_go   = s_axi_arvalid & s_axi_arready;
  wire rd_ok   = (s_axi_araddr == MODE_OFS) | (s_axi_araddr == STAT_OFS) |
                 (s_axi_araddr == MASK_OFS) | (s_axi_araddr == PINS_OFS);
  wire [7:0] rd_byte =
    (s_axi_araddr == MODE_OFS) ? mode_ff :
    (s_axi_araddr == STAT_OFS) ? {4'h0, stat_ff} :
    (s_axi_araddr == MASK_OFS) ? {4'h0, mask_ff} :
    (s_axi_araddr == PINS_OFS) ? {4'h0, pin2_ff.oe, pin2_ff.o,
                                  pin1_ff.oe, pin1_ff.o} : 8'h00;

  // Reserved bits held at zero regardless of what is written
  wire [7:0] nxt_mode = wr_mode ? (wdata_ff[7:0] & MODE_WMASK) : mode_ff;
  wire [3:0] nxt_stat = events | (stat_ff & ~(wr_stat ? wdata_ff[3:0]
                                                       : 4'h0));
  wire [3:0] nxt_mask = wr_mask ? wdata_ff[3:0] : mask_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_ff <= MODE_RST;
      stat_ff <= IRQ_RST;
      mask_ff <= IRQ_RST;
      prev_req_ff <= 2'b00;
    end else begin
      mode_ff <= nxt_mode;
      stat_ff <= nxt_stat;
      mask_ff <= nxt_mask;
      prev_req_ff <= cur_req;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin1_ff <= '0;
      pin2_ff <= '0;
      irq_ff  <= 1'b0;
      midi_ff <= 1'b0;
      hs_ff   <= 1'b0;
    end else begin
      pin1_ff <= '{o: nxt_o1, oe: nxt_oe1};
      pin2_ff <= '{o: nxt_o2, oe: nxt_oe2};
      irq_ff  <= |(nxt_stat & nxt_mask);
      midi_ff <= nxt_mode[MIDI_BIT];
      hs_ff   <= nxt_mode[HS_BIT];
    end
  end

  // Write channel: address and data taken in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_ff <= 1'b0;
      w_ff  <= 1'b0;
      awaddr_ff <= 8'h00;
      wdata_ff  <= 32'h0000_0000;
      wstrb_ff  <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_ff <= 1'b1;
        awaddr_ff <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_ff <= 1'b1;
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_ff <= 1'b0;
        w_ff  <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  assign s_axi_awready = ~aw_ff & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_ff & ~s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= RESP_OKAY;
    end else if (rd_go) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= {24'h000000, rd_byte};
      s_axi_rresp  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  assign s_axi_arready = ~s_axi_rvalid;
  assign irq_pin_one   = pin1_ff;
  assign irq_pin_two   = pin2_ff;
  assign midi_en       = midi_ff;
  assign high_speed_en = hs_ff;
  assign irq           = irq_ff;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence shared_req_s;
    share && any_req;
  endsequence

  sequence shared_idle_s;
    share && any_gate && !any_req;
  endsequence

  sequence shared_off_s;
    share && !any_gate;
  endsequence

  mode_reset_zero_a: assert property (
      $rose(aresetn) |-> mode_ff == 8'h00)
    else $error("mode not zero after reset");
  midi_follow_a: assert property (wr_mode |=> ##1
      midi_en == $past(wdata_ff[0], 2))
    else $error("midi enable not from mode write");
  hs_follow_a: assert property (wr_mode |=> ##1
      high_speed_en == $past(wdata_ff[1], 2))
    else $error("high speed enable not from mode write");
  reserved_zero_a: assert property (mode_ff[6:2] == 5'h00)
    else $error("reserved mode bits set");
  own_pin_a: assert property (!share |=>
      irq_pin_one.o == $past(req1) && irq_pin_two.o == $past(req2))
    else $error("unshared pin shows wrong port");
  shared_high_a: assert property (shared_req_s |=>
      irq_pin_one.o && irq_pin_one.oe &&
      irq_pin_two.o && irq_pin_two.oe)
    else $error("shared pins not both driven high");
  shared_low_a: assert property (shared_idle_s |=>
      irq_pin_one.oe && !irq_pin_one.o &&
      irq_pin_two.oe && !irq_pin_two.o)
    else $error("shared pins not both driven low");
  shared_float_a: assert property (shared_off_s |=>
      !irq_pin_one.oe && !irq_pin_two.oe)
    else $error("shared pins driven with no gate");
  float_pin_a: assert property (!share && !serial_port_one.gate |=>
      !irq_pin_one.oe)
    else $error("ungated pin driven");
  float_two_a: assert property (!share && !serial_port_two.gate |=>
      !irq_pin_two.oe)
    else $error("ungated pin two driven");
  both_assert_a: assert property (share && req1 && !req2 |=>
      irq_pin_two.o && irq_pin_two.oe)
    else $error("other pin missed shared request");
  // A clear in the same cycle as an event must not lose the event
  set_wins_a: assert property ((|events) |=>
      (stat_ff & $past(events)) == $past(events))
    else $error("status event lost");
  irq_level_a: assert property (irq == |(stat_ff & mask_ff))
    else $error("interrupt output not status and mask");
endmodule
`default_nettype wire

// File: tb/uirq_route_test.sv
// Self-checking bench for the serial-port interrupt routing block.
// Assumes the design package, the block and the line-sampling model.
`timescale 1ns/1ps
`default_nettype none
module uirq_route_test
  import uirq_pkg::*;
();
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, midi, hs, irq;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, seen, rsp;
  uirq_port_t  p1, p2;
  uirq_pin_t   pin1, pin2;
  int          err_total, compares;
  uirq_route u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .serial_port_one(p1), .serial_port_two(p2),
    .irq_pin_one(pin1), .irq_pin_two(pin2), .midi_en(midi),
    .high_speed_en(hs), .irq(irq));
  uirq_sic_model u_sic (.aclk(aclk), .pin_a(pin1), .pin_b(pin2),
    .seen(seen));
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ad, wd;
    ad = 1'b0;
    wd = 1'b0;
    @(posedge aclk);
    awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    while (!(ad && wd)) begin
      @(posedge aclk);
      if (!ad && awready) begin ad = 1'b1; awvalid <= 1'b0; end
      if (!wd && wready) begin wd = 1'b1; wvalid <= 1'b0; end
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    rsp = bresp;
    bready <= 1'b0;
  endtask
  task automatic rdr(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rd = rdata; rsp = rresp;
    rready <= 1'b0;
  endtask
  task automatic t_regs;
    rdr(MODE_OFS); chk(rd, 32'h0); chk({midi, hs}, 2'b00);
    wr(MODE_OFS, 32'h83); rdr(MODE_OFS); chk(rd, 32'h83);
    chk({midi, hs}, 2'b11);
    wr(MODE_OFS, 32'h01); @(posedge aclk); chk({midi, hs}, 2'b10);
    wstrb <= 4'h0;
    wr(MODE_OFS, 32'h82); chk(rsp, RESP_OKAY);
    wstrb <= 4'hf;
    rdr(MODE_OFS); chk(rd, 32'h01);
    wr(8'h10, 32'h1); chk(rsp, RESP_SLVERR);
    rdr(8'h10); chk(rsp, RESP_SLVERR); chk(rd, 32'h0);
    $display("test regs done");
  endtask
  task automatic t_pins;
    logic g1, r1, g2, r2, v;
    for (int s = 0; s < 2; s++) begin
      wr(MODE_OFS, {24'h0, s[0], 7'h0});
      for (int k = 0; k < 16; k++) begin
        {g1, r1, g2, r2} = k[3:0];
        p1 <= {g1, r1}; p2 <= {g2, r2};
        repeat (3) @(posedge aclk);
        v = (g1 & r1) | (g2 & r2);
        if (s == 0) chk(seen, {g2 ? r2 : 1'bz, g1 ? r1 : 1'bz});
        else chk(seen, (g1 | g2) ? {v, v} : 2'bzz);
        rdr(PINS_OFS);
        if (s == 0) chk(rd, {28'h0, g2, g2 & r2, g1, g1 & r1});
        else chk(rd, {28'h0, g1 | g2, v, g1 | g2, v});
      end
    end
    $display("test pins done");
  endtask
  task automatic t_irq;
    p1 <= 2'b10; p2 <= 2'b10;
    wr(MODE_OFS, 32'h0); wr(STAT_OFS, 32'hf); wr(MASK_OFS, 32'h1);
    rdr(MASK_OFS); chk(rd, 32'h1);
    chk(irq, 1'b0);
    p1 <= 2'b11; repeat (4) @(posedge aclk); chk(irq, 1'b1);
    rdr(STAT_OFS); chk(rd[0], 1'b1);
    wr(MASK_OFS, 32'h0); @(posedge aclk); chk(irq, 1'b0);
    wr(STAT_OFS, 32'h1); rdr(STAT_OFS); chk(rd[0], 1'b0);
    p1 <= 2'b01;
    wr(MASK_OFS, 32'h4); @(posedge aclk); chk(irq, 1'b1);
    rdr(STAT_OFS); chk(rd[2], 1'b1);
    p1 <= 2'b00;
    wr(STAT_OFS, 32'hf); @(posedge aclk); chk(irq, 1'b0);
    $display("test irq done");
  endtask
  task automatic final_report;
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    aresetn = 1'b0; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0;
    arvalid = 1'b0; rready = 1'b0; awaddr = 8'h0; araddr = 8'h0;
    wdata = 32'h0; wstrb = 4'hf; p1 = 2'b00; p2 = 2'b00;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs;
    t_pins;
    t_irq;
    final_report;
  end
  initial begin
    repeat (20000) @(posedge aclk);
    err_total++;
    final_report;
  end
endmodule
`default_nettype wire

// File: tb/uirq_sic_model.sv
// Interrupt controller model that samples the two request lines.
// Assumes pins are registered on aclk; a released line reads as z.
`timescale 1ns/1ps
`default_nettype none
module uirq_sic_model
  import uirq_pkg::*;
(
  input  wire logic      aclk,
  input  wire uirq_pin_t pin_a,
  input  wire uirq_pin_t pin_b,
  output logic [1:0]     seen
);
  // Undriven line stays z, so a floating pin never passes as a level
  always_ff @(posedge aclk) begin
    seen <= {pin_b.oe ? pin_b.o : 1'bz, pin_a.oe ? pin_a.o : 1'bz};
  end
endmodule
`default_nettype wire
